// file: hpmd_pkg.sv
// Shared types and constants for the parallel host port strobe and mode decoder.
// Assumes a single core clock with synchronous, active-low reset.
package hpmd_pkg;
	// ****************************************
	// Strap encodings and reset values
	// ****************************************
	localparam logic STYLE_SEPARATE = 1'b0;
	localparam logic STYLE_DATA_STROBE = 1'b1;
	localparam logic [7:0] RST_DATA = 8'h00;
	localparam logic [7:0] RST_ADDR = 8'h00;
	localparam logic RST_INT = 1'b0;
	localparam logic RST_RDY = 1'b0;
	localparam logic RST_OE = 1'b0;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		HPMD_IDLE = 2'h0,
		HPMD_WAIT = 2'h1,
		HPMD_ACK = 2'h3
	} hpmd_state_t;

	typedef struct packed {
		logic write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} hpmd_req_t;
endpackage

// file: hpmd_port.sv
// Host port front end: decodes strap-selected bus styles into core access requests.
// Assumes host pins are synchronous to clk_in and that straps stay stable between accesses.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - The multiplex strap high means a multiplexed address phase, low means the address sits on dedicated lines.
// - The shared lowest address pin is address bit zero when not multiplexed and the latch enable when multiplexed.
// - The write or data strobe pin is an active-low write enable or an active-low data strobe depending on style.
// - The read pin is an active-low read enable in separate style and a read-high, write-low line in strobe style.
// - The interrupt output is active high in separate style and active low in strobe style.
// - Access completion shows on the ready output as active-high ready or active-low acknowledge, floating at reset.
module hpmd_port (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic bus_style_in,
	input wire logic mux_in,
	input wire logic [6:0] addr_hi_in,
	input wire logic addr0_ale_in,
	input wire logic [7:0] data_in,
	input wire logic sel_n_in,
	input wire logic write_or_data_strobe_n_in,
	input wire logic rd_rw_in,
	input wire logic irq_in,
	input wire logic acc_done_in,
	input wire logic [7:0] acc_rdata_in,
	output logic [7:0] data_out,
	output logic data_oe_out,
	output logic int_out,
	output logic rdy_out,
	output logic rdy_oe_out,
	output logic acc_valid_out,
	output hpmd_pkg::hpmd_req_t acc_req_out
);
	import hpmd_pkg::*;

	// ****************************************
	// Pin decoding
	// ****************************************
	wire logic selected = !sel_n_in;
	wire logic strobe_low = !write_or_data_strobe_n_in;
	wire logic style_ds = (bus_style_in == STYLE_DATA_STROBE);
	wire logic rd_sep = selected && !rd_rw_in;
	wire logic wr_sep = selected && strobe_low;
	wire logic ds_act = selected && strobe_low;
	wire logic rd_ds = ds_act && rd_rw_in;
	wire logic write_or_data_strobe_n = ds_act && !rd_rw_in;
	wire logic rd_act = style_ds ? rd_ds : rd_sep;
	wire logic wr_act = style_ds ? write_or_data_strobe_n : wr_sep;
	wire logic acc_act = rd_act || wr_act;
	wire logic ale_act = mux_in && addr0_ale_in;

	// In multiplexed mode bit zero travels on the data lines during the latch pulse.
	logic [7:0] alat_q;
	wire logic [7:0] addr_mux = alat_q;
	wire logic [7:0] addr_direct = {addr_hi_in, addr0_ale_in};
	wire logic [7:0] addr_sel = mux_in ? addr_mux : addr_direct;

	// ****************************************
	// Access sequencer
	// ****************************************
	hpmd_state_t state_q;
	hpmd_state_t state_d;
	logic [7:0] rdata_q;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			HPMD_IDLE: begin
				if (acc_act) begin
					state_d = HPMD_WAIT;
				end
			end
			HPMD_WAIT: begin
				// A host that drops its strobe early aborts the access rather than hanging the port.
				if (!acc_act) begin
					state_d = HPMD_IDLE;
				end else if (acc_done_in) begin
					state_d = HPMD_ACK;
				end
			end
			HPMD_ACK: begin
				if (!acc_act) begin
					state_d = HPMD_IDLE;
				end
			end
			default: begin
				state_d = HPMD_IDLE;
			end
		endcase
	end

	wire logic start = (state_q == HPMD_IDLE) && acc_act;
	// Ready is driven only while an access is open, so the pin floats between accesses and in reset.
	wire logic rdy_oe_d = (state_d != HPMD_IDLE);
	wire logic rdy_d = style_ds ? (state_d != HPMD_ACK) : (state_d == HPMD_ACK);
	wire logic data_oe_d = rd_act && (state_d == HPMD_ACK);
	wire logic int_d = style_ds ? !irq_in : irq_in;
	wire logic capture = (state_q == HPMD_WAIT) && acc_act && acc_done_in;
	wire hpmd_req_t req_d = '{write: wr_act, addr: addr_sel, wdata: data_in};

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			state_q <= HPMD_IDLE;
			alat_q <= RST_ADDR;
			rdata_q <= RST_DATA;
		end else begin
			state_q <= state_d;
			if (ale_act) begin
				alat_q <= {addr_hi_in, data_in[0]};
			end
			if (capture) begin
				rdata_q <= acc_rdata_in;
			end
		end
	end

	// ****************************************
	// Registered pin and core outputs
	// ****************************************
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			data_out <= RST_DATA;
			data_oe_out <= RST_OE;
			int_out <= RST_INT;
			rdy_out <= RST_RDY;
			rdy_oe_out <= RST_OE;
			acc_valid_out <= 1'b0;
			acc_req_out <= '0;
		end else begin
			data_out <= capture ? acc_rdata_in : rdata_q;
			data_oe_out <= data_oe_d;
			int_out <= int_d;
			rdy_out <= rdy_d;
			rdy_oe_out <= rdy_oe_d;
			acc_valid_out <= start;
			if (start) begin
				acc_req_out <= req_d;
			end
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	mode_pick_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		acc_valid_out |-> acc_req_out.write == ($past(bus_style_in) ? !$past(rd_rw_in) : $past(strobe_low)))
		else $error("Access direction does not follow the bus style strap.");

	mux_addr_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(acc_valid_out && !$past(mux_in)) |-> acc_req_out.addr == $past({addr_hi_in, addr0_ale_in}))
		else $error("Non-multiplexed address not taken from dedicated lines.");

	ale_latch_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(mux_in && addr0_ale_in) |=> alat_q == $past({addr_hi_in, data_in[0]}))
		else $error("Latch enable did not capture the address.");

	write_start_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(state_q == HPMD_IDLE && wr_act) |=> acc_valid_out && acc_req_out.write)
		else $error("Write strobe did not start a write access.");

	read_start_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(state_q == HPMD_IDLE && rd_act) |=> acc_valid_out && !acc_req_out.write)
		else $error("Read strobe did not start a read access.");

	irq_pol_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		$past(nrst_in) |-> int_out == ($past(bus_style_in) ^ $past(irq_in)))
		else $error("Interrupt polarity wrong for the bus style.");

	ready_ack_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		capture |=> rdy_oe_out && (rdy_out == !$past(bus_style_in)) && (data_oe_out == $past(rd_act)))
		else $error("Completion not shown on the ready pin.");

	bus_float_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		data_oe_out |-> $past(rd_act) && rdy_oe_out)
		else $error("Data lines driven outside a selected read.");

	ready_wait_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		acc_valid_out |-> rdy_oe_out && (rdy_out == $past(bus_style_in)))
		else $error("Ready pin not at its waiting level when an access opens.");

	ready_idle_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!$past(acc_act) |-> !rdy_oe_out)
		else $error("Ready pin driven with no access active.");

	ready_reset_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!$past(nrst_in) |-> !rdy_oe_out)
		else $error("Ready pin driven out of reset.");

	data_reset_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!$past(nrst_in) |-> !data_oe_out)
		else $error("Data lines driven out of reset.");

	read_data_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		capture |=> data_out == $past(acc_rdata_in))
		else $error("Read data on the pins differs from the core data.");

	mux_latch_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(acc_valid_out && $past(mux_in)) |-> acc_req_out.addr == $past(alat_q))
		else $error("Multiplexed address not taken from the latch.");

	sep_write_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(state_q == HPMD_IDLE && !sel_n_in && strobe_low && rd_rw_in && bus_style_in == STYLE_SEPARATE)
		|=> acc_valid_out && acc_req_out.write)
		else $error("Separate-style write enable did not start a write.");

	ds_write_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(state_q == HPMD_IDLE && !sel_n_in && strobe_low && !rd_rw_in && bus_style_in == STYLE_DATA_STROBE)
		|=> acc_valid_out && acc_req_out.write)
		else $error("Data strobe with write level did not start a write.");

	sep_read_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(state_q == HPMD_IDLE && !sel_n_in && !strobe_low && !rd_rw_in && bus_style_in == STYLE_SEPARATE)
		|=> acc_valid_out && !acc_req_out.write)
		else $error("Separate-style read enable did not start a read.");

	ds_read_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(state_q == HPMD_IDLE && !sel_n_in && strobe_low && rd_rw_in && bus_style_in == STYLE_DATA_STROBE)
		|=> acc_valid_out && !acc_req_out.write)
		else $error("Data strobe with read level did not start a read.");

	ds_idle_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(state_q == HPMD_IDLE && bus_style_in == STYLE_DATA_STROBE && !strobe_low) |=> !acc_valid_out)
		else $error("Access started without the data strobe.");

	deselect_quiet_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		sel_n_in |=> !acc_valid_out)
		else $error("Access started without chip select.");
endmodule

`default_nettype wire

// file: hpmd_host.sv
// Host bus model that drives the parallel port pins one access at a time.
// Assumes the bench sets the straps to match the style passed to each access.
`timescale 1ns/1ps
`default_nettype none
module hpmd_host (
	input wire logic clk_in,
	input wire logic rdy_in,
	input wire logic rdy_oe_in,
	output logic [6:0] addr_hi_out,
	output logic ale_out,
	output logic [7:0] data_out,
	output logic sel_n_out,
	output logic write_or_data_strobe_n_n_out,
	output logic rd_rw_out
);
	initial begin
		{addr_hi_out, ale_out, data_out} = '0;
		{sel_n_out, write_or_data_strobe_n_n_out, rd_rw_out} = 3'h7;
	end
	task automatic access(input logic st, mx, wr, input logic [7:0] a, wd, output logic ok);
		int n;
		@(posedge clk_in);
		addr_hi_out <= a[7:1];
		ale_out <= mx | a[0];
		data_out <= mx ? {7'h00, a[0]} : wd;
		if (mx) begin
			@(posedge clk_in);
			ale_out <= 1'b0;
			data_out <= wd;
		end
		@(posedge clk_in);
		sel_n_out <= 1'b0;
		write_or_data_strobe_n_n_out <= st ? 1'b0 : !wr;
		rd_rw_out <= st ? !wr : wr;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (!(rdy_oe_in === 1'b1 && rdy_in === !st) && n < 40);
		ok = n < 40;
		{sel_n_out, write_or_data_strobe_n_n_out, rd_rw_out} <= 3'h7;
		// A released bus shows the inverse so a stale value cannot pass.
		data_out <= ~wd;
	endtask
endmodule
`default_nettype wire

// file: hpmd_port_bench.sv
// Self-checking bench for the host port decoder with a host model and a core responder.
// Assumes one 200 MHz clock and the host model in its own file.
`timescale 1ns/1ps
`default_nettype none
module hpmd_port_bench;
	import hpmd_pkg::*;
	logic clk = 0, nrst = 0, style = 0, mux = 0, irq = 0, done = 0, ok, wr;
	logic [7:0] rdata = 8'h00, pins, dq, hd, a, wd;
	logic [6:0] ahi;
	logic ale, sel_n, ws_n, rw, doe, intp, rdy, roe, val;
	hpmd_req_t req, seen;
	int err_count = 0, compares = 0, cnt = 0;
	always #2.5 clk = ~clk;
	assign pins = doe ? dq : hd;
	hpmd_host i_host (.clk_in(clk), .rdy_in(rdy), .rdy_oe_in(roe), .addr_hi_out(ahi), .ale_out(ale),
		.data_out(hd), .sel_n_out(sel_n), .write_or_data_strobe_n_n_out(ws_n), .rd_rw_out(rw));
	hpmd_port i_dut (.clk_in(clk), .nrst_in(nrst), .bus_style_in(style), .mux_in(mux), .addr_hi_in(ahi),
		.addr0_ale_in(ale), .data_in(pins), .sel_n_in(sel_n), .write_or_data_strobe_n_in(ws_n),
		.rd_rw_in(rw), .irq_in(irq), .acc_done_in(done), .acc_rdata_in(rdata), .data_out(dq),
		.data_oe_out(doe), .int_out(intp), .rdy_out(rdy), .rdy_oe_out(roe), .acc_valid_out(val),
		.acc_req_out(req));
	always @(posedge clk) begin
		done <= cnt == 1;
		if (val) begin
			cnt <= $urandom_range(1, 4);
			seen <= req;
			rdata <= 8'($urandom);
		end else if (cnt != 0) begin
			cnt <= cnt - 1;
		end
	end
	task automatic chk(input string nm, input logic [16:0] e, g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#20000;
		err_count++;
		summarize();
	end
	initial begin
		void'($urandom(41));
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		#1 chk("reset_float", 0, {roe, doe});
		for (int i = 0; i < 24; i++) begin
			wr = 1'($urandom);
			a = i < 4 ? {8{i[1]}} : 8'($urandom);
			wd = 8'($urandom);
			@(posedge clk);
			style <= i[0];
			mux <= i[1];
			irq <= i[2];
			i_host.access(i[0], i[1], wr, a, wd, ok);
			#1 chk("done", 1, ok);
			chk("req", {wr, a, wd}, seen);
			if (!wr) chk("rdata", {1'b1, rdata}, {doe, dq});
			chk("int", i[0] ^ i[2], intp);
			repeat (2) @(posedge clk);
			#1 chk("idle", 0, {roe, doe});
		end
		summarize();
	end
endmodule
`default_nettype wire
